//--- pkg/ckg_cfg.svh
// Purpose: constants of the reference clock generator control block
// Assumes: mclk at 40 MHz
// Notes:   offsets, field positions, reset values and timing counts
`ifndef CKG_CFG_SVH
`define CKG_CFG_SVH

`define CKG_NUM_OUT      6
`define CKG_CLK_NS       25
// longest times, rounded down to whole cycles
`define CKG_STAB_MS      1.8
`define CKG_STAB_CYC     ($rtoi(`CKG_STAB_MS * 1.0e6 / `CKG_CLK_NS))
`define CKG_DRVPD_US     300
`define CKG_DRVPD_CYC    ((`CKG_DRVPD_US * 1000) / `CKG_CLK_NS)
// half period of the modelled output clock, in mclk cycles
`define CKG_HALF_CYC     2'h2
`define CKG_TIMER_W      17

`define CKG_ADDR_B1      3'h1
`define CKG_ADDR_B3      3'h3
`define CKG_ADDR_ST      3'h4
`define CKG_SPREAD_LSB   3
`define CKG_WOL_BIT      5
`define CKG_B1_RST       8'h00
`define CKG_B3_RST       8'h00

`define CKG_SPR_NOSS     2'h0
`define CKG_SPR_025      2'h1
`define CKG_SPR_000      2'h2
`define CKG_SPR_050      2'h3

`endif

//--- pkg/ckg_pkg.sv
// Purpose: types of the reference clock generator control block
// Assumes: constants come from ckg_cfg.svh
// Notes:   one packed state struct per module
`default_nettype none
package ckg_pkg;
    typedef enum logic [1:0] {CKG_TRI_LOW, CKG_TRI_MID, CKG_TRI_HIGH} ckg_tri_e;

    typedef enum logic [1:0] {CKG_ST_WAIT_PG, CKG_ST_START, CKG_ST_RUN, CKG_ST_PD} ckg_state_e;

    typedef struct packed {
        ckg_state_e  st;
        logic        latched;
        ckg_tri_e    tri_sel;
        logic        addr_sel;
        logic [16:0] timer;
        logic        from_pd;
        logic        fault;
        logic [1:0]  div;
        logic        phase;
        logic        rise;
        logic        fall;
        logic        allow;
        logic [1:0]  spread;
        logic        mode_common;
        logic        xtal;
        logic        ref_o;
        logic        ref_oe;
        logic        pll_en;
        logic        latch_pulse;
    } ckg_top_s;

    typedef struct packed {
        logic       req;
        logic       on;
        logic       p;
        logic       n;
    } ckg_gate_s;

    typedef struct packed {
        logic [7:0] b1;
        logic [7:0] b3;
        logic [7:0] rdata;
        logic       mode_low;
    } ckg_reg_s;
endpackage : ckg_pkg
`default_nettype wire

//--- pkg/ckg_cfg_if.sv
// Purpose: carrier between control core and configuration bytes
// Assumes: single clock domain
// Notes:   latch_load is a one-cycle pulse
`default_nettype none
interface ckg_cfg_if;
    logic [1:0]       spread_field;
    logic             wol;
    logic             latch_load;
    ckg_pkg::ckg_tri_e latch_tri;
    logic [7:0]       status;

    modport regs (output spread_field, output wol,
                  input latch_load, input latch_tri, input status);
    modport core (input spread_field, input wol,
                  output latch_load, output latch_tri, output status);
endinterface : ckg_cfg_if
`default_nettype wire

//--- hdl/ckg_out_gate.sv
// Purpose: one differential output gate
// Assumes: rise and fall are one-cycle boundary pulses of the output clock
// Notes:   enable changes take effect only on a rising boundary
`default_nettype none
module ckg_out_gate (
    input  wire logic mclk,
    input  wire logic resetn,
    input  wire logic rise,
    input  wire logic fall,
    input  wire logic allow,
    input  wire logic en_n,
    output logic      clk_p,
    output logic      clk_n
);
    ckg_pkg::ckg_gate_s s_q;
    ckg_pkg::ckg_gate_s s_d;

    always_comb begin
        s_d = s_q;
        if (rise) begin
            // sampled one boundary earlier: latency stays in 1..2 periods
            s_d.req = allow & ~en_n;                   // [R1]
            s_d.on  = s_q.req;                         // [R9] [R17]
            s_d.p   = s_q.req;
            s_d.n   = 1'b0;
        end else if (fall) begin
            s_d.p = 1'b0;
            s_d.n = s_q.on;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign clk_p = s_q.p;
    assign clk_n = s_q.n;

    a_gate_latency: assert property (@(posedge mclk) disable iff (!resetn) // [R9]
        rise && s_q.req |=> s_q.on && s_q.p)
        else $error("enabled output did not start at the boundary");
    a_gate_whole: assert property (@(posedge mclk) disable iff (!resetn) // [R17]
        $fell(s_q.on) |-> $past(rise))
        else $error("output stopped away from a boundary");
endmodule : ckg_out_gate
`default_nettype wire

//--- hdl/ckg_cfg_regs.sv
// Purpose: configuration bytes and read port
// Assumes: strobes one cycle long, never both at once
// Notes:   read data stand only in the cycle after the read strobe
`default_nettype none
`include "ckg_cfg.svh"
module ckg_cfg_regs (
    input  wire logic       mclk,
    input  wire logic       resetn,
    input  wire logic [2:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic [7:0]      reg_rdata,
    ckg_cfg_if.regs         cfg
);
    ckg_pkg::ckg_reg_s s_q;
    ckg_pkg::ckg_reg_s s_d;

    function automatic logic [1:0] tri_code(input ckg_pkg::ckg_tri_e t);
        unique case (t)
            ckg_pkg::CKG_TRI_LOW:  tri_code = `CKG_SPR_NOSS;
            ckg_pkg::CKG_TRI_MID:  tri_code = `CKG_SPR_000;
            ckg_pkg::CKG_TRI_HIGH: tri_code = `CKG_SPR_050;
            default:               tri_code = `CKG_SPR_050;
        endcase
    endfunction : tri_code

    always_comb begin
        s_d = s_q;
        s_d.rdata = 8'h00;
        if (cfg.latch_load) begin
            // default spread taken from the strap, no bus access needed
            s_d.b1[`CKG_SPREAD_LSB +: 2] = tri_code(cfg.latch_tri);     // [R4] [R14]
            s_d.mode_low = (cfg.latch_tri == ckg_pkg::CKG_TRI_LOW);
        end else if (reg_wr) begin
            if (reg_addr == `CKG_ADDR_B1) begin
                s_d.b1 = reg_wdata;                                       // [R5]
                // protective: a wrong mode write would need a full reset
                if (s_q.mode_low) begin
                    s_d.b1[`CKG_SPREAD_LSB +: 2] = `CKG_SPR_NOSS;        // [R6]
                end else if (reg_wdata[`CKG_SPREAD_LSB +: 2] == `CKG_SPR_NOSS) begin
                    s_d.b1[`CKG_SPREAD_LSB +: 2] = s_q.b1[`CKG_SPREAD_LSB +: 2]; // [R7]
                end
            end else if (reg_addr == `CKG_ADDR_B3) begin
                s_d.b3 = reg_wdata;
            end
        end
        if (reg_rd) begin
            if (reg_addr == `CKG_ADDR_B1) begin
                s_d.rdata = s_q.b1;
            end else if (reg_addr == `CKG_ADDR_B3) begin
                s_d.rdata = s_q.b3;
            end else if (reg_addr == `CKG_ADDR_ST) begin
                s_d.rdata = cfg.status;
            end
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            s_q.b1       <= `CKG_B1_RST;
            s_q.b3       <= `CKG_B3_RST;
            s_q.rdata    <= 8'h00;
            s_q.mode_low <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata        = s_q.rdata;
    assign cfg.spread_field = s_q.b1[`CKG_SPREAD_LSB +: 2];
    assign cfg.wol          = s_q.b3[`CKG_WOL_BIT];

    a_nospread_locked: assert property (@(posedge mclk) disable iff (!resetn) // [R6]
        s_q.mode_low && !cfg.latch_load |=> cfg.spread_field == `CKG_SPR_NOSS)
        else $error("spread field left separate-reference no-spread mode");
    a_spread_write: assert property (@(posedge mclk) disable iff (!resetn) // [R5]
        reg_wr && reg_addr == `CKG_ADDR_B1 && !s_q.mode_low && !cfg.latch_load
        && reg_wdata[4:3] != 2'h0 |=> cfg.spread_field == $past(reg_wdata[4:3]))
        else $error("spread write not accepted");
endmodule : ckg_cfg_regs
`default_nettype wire

//--- hdl/ckg_ctrl.sv
// Purpose: control and sequencing of a six-output reference clock generator
// Assumes: resetn is supply power-on; pins synchronous to mclk
// Notes:   the output clock is modelled as a divided mclk square wave
//
// What this block does
// (R1) six active-low enables, low enables output
// (R2) first power-good high latches straps, starts up
// (R3) later low powers down, high resumes, no resample
// (R4) tri-level spread strap sets initial spread, mode
// (R5) mid/high strap: spread field changes without reset
// (R6) host keeps field at 00 after low strap
// (R7) host never selects 00 after mid/high strap
// (R8) address strap latched, pin then copies reference
// (R9) outputs start/stop within 1..3 output clocks
// (R10) outputs back within 300 us of power-down exit; a later lock only sets startup_fault
// (R11) first clock within 1.8 ms of start; a later lock only sets startup_fault
// (R12) outputs blocked until the PLL reports lock
// (R13) spread changes applied glitch free
// (R14) runs from defaults without any bus access
// (R15) six 100 MHz outputs from 25 MHz reference
// (R16) wake-on-lan bit keeps reference running in power-down
// (R17) transitions only on output clock boundaries
// (R18) latched straps kept until power removed
`default_nettype none
`include "ckg_cfg.svh"
module ckg_ctrl #(
    parameter int unsigned STAB_CYC  = `CKG_STAB_CYC,
    parameter int unsigned DRVPD_CYC = `CKG_DRVPD_CYC
) (
    input  wire logic       mclk,
    input  wire logic       resetn,
    input  wire logic       power_good_powerdown_n,
    input  wire logic [1:0] spread_select_tri,
    input  wire logic [5:0] out_enable_n,
    input  wire logic       xtal_in,
    input  wire logic       pll_lock,
    input  wire logic       bus_address_latch_ref_copy_i,
    output logic            bus_address_latch_ref_copy_o,
    output logic            bus_address_latch_ref_copy_oe,
    output logic [5:0]      diff_clk_out_p,
    output logic [5:0]      diff_clk_out_n,
    output logic            pll_enable,
    output logic [1:0]      spread_code,
    output logic            common_clock_mode,
    output logic            bus_addr_sel,
    output logic            startup_fault,
    input  wire logic [2:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic [7:0]      reg_rdata
);
    ckg_pkg::ckg_top_s s_q;
    ckg_pkg::ckg_top_s s_d;
    ckg_cfg_if         cfg ();

    logic              ref_run;
    logic              lim_hit;

    // a stray fourth code on the strap input reads as high
    function automatic ckg_pkg::ckg_tri_e tri_decode(input logic [1:0] v);
        unique case (v)
            2'h0:    tri_decode = ckg_pkg::CKG_TRI_LOW;
            2'h1:    tri_decode = ckg_pkg::CKG_TRI_MID;
            default: tri_decode = ckg_pkg::CKG_TRI_HIGH;
        endcase
    endfunction : tri_decode

    // power-down exit has the tighter bound of the two
    assign lim_hit = s_q.from_pd ? (32'(s_q.timer) >= DRVPD_CYC)        // [R10]
                                 : (32'(s_q.timer) >= STAB_CYC);        // [R11]

    always_comb begin
        s_d = s_q;
        s_d.rise = 1'b0;
        s_d.fall = 1'b0;
        s_d.latch_pulse = 1'b0;
        s_d.xtal = xtal_in;
        // output clock divider; rise and fall mark the period boundaries
        if (s_q.div == `CKG_HALF_CYC - 2'h1) begin
            s_d.div   = 2'h0;
            s_d.phase = ~s_q.phase;
            s_d.rise  = ~s_q.phase;                                     // [R15]
            s_d.fall  = s_q.phase;
        end else begin
            s_d.div = s_q.div + 2'h1;
        end
        unique case (s_q.st)
            ckg_pkg::CKG_ST_WAIT_PG: begin
                if (power_good_powerdown_n) begin
                    s_d.latched     = 1'b1;                             // [R2]
                    s_d.tri_sel     = tri_decode(spread_select_tri);    // [R4]
                    s_d.addr_sel    = bus_address_latch_ref_copy_i;     // [R8]
                    s_d.mode_common = (tri_decode(spread_select_tri)
                                       != ckg_pkg::CKG_TRI_LOW);
                    s_d.latch_pulse = 1'b1;
                    s_d.ref_oe      = 1'b1;
                    s_d.pll_en      = 1'b1;
                    s_d.timer       = '0;
                    s_d.from_pd     = 1'b0;
                    s_d.st          = ckg_pkg::CKG_ST_START;
                end
            end
            ckg_pkg::CKG_ST_START: begin
                if (!power_good_powerdown_n) begin
                    s_d.pll_en = 1'b0;
                    s_d.st     = ckg_pkg::CKG_ST_PD;                   // [R3]
                end else if (pll_lock) begin
                    s_d.st = ckg_pkg::CKG_ST_RUN;                       // [R12]
                end else begin
                    if (s_q.timer != '1) begin
                        s_d.timer = s_q.timer + 17'h1;
                    end
                    if (lim_hit) begin
                        s_d.fault = 1'b1;                               // [R10] [R11]
                    end
                end
            end
            ckg_pkg::CKG_ST_RUN: begin
                if (!power_good_powerdown_n) begin
                    s_d.pll_en = 1'b0;
                    s_d.st     = ckg_pkg::CKG_ST_PD;                   // [R3]
                end else if (!pll_lock) begin
                    s_d.timer = '0;
                    s_d.st    = ckg_pkg::CKG_ST_START;                 // [R12]
                end
            end
            ckg_pkg::CKG_ST_PD: begin
                if (power_good_powerdown_n) begin
                    // straps are not sampled again here
                    s_d.pll_en  = 1'b1;
                    s_d.timer   = '0;
                    s_d.from_pd = 1'b1;
                    s_d.st      = ckg_pkg::CKG_ST_START;               // [R3] [R18]
                end
            end
        endcase
        // gates stop at the second boundary after allow drops
        s_d.allow = (s_d.st == ckg_pkg::CKG_ST_RUN) && pll_lock;        // [R12] [R17]
        if (s_q.rise) begin
            s_d.spread = cfg.spread_field;                              // [R13] [R5]
        end
        s_d.ref_o = ref_run & s_q.xtal;                                 // [R8] [R16]
    end

    // reference copy only after the address strap is taken
    assign ref_run = s_q.latched && ((s_q.st != ckg_pkg::CKG_ST_PD) || cfg.wol); // [R16]

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign cfg.latch_load = s_q.latch_pulse;
    assign cfg.latch_tri  = s_q.tri_sel;
    assign cfg.status     = {1'b0, s_q.addr_sel, s_q.tri_sel, s_q.fault, s_q.allow,
                             (s_q.st == ckg_pkg::CKG_ST_PD), s_q.latched};

    ckg_cfg_regs u_regs (
        .mclk      (mclk),
        .resetn    (resetn),
        .reg_addr  (reg_addr),
        .reg_wdata (reg_wdata),
        .reg_wr    (reg_wr),
        .reg_rd    (reg_rd),
        .reg_rdata (reg_rdata),
        .cfg       (cfg.regs)
    );

    for (genvar g = 0; g < `CKG_NUM_OUT; g++) begin : g_out
        ckg_out_gate u_gate (
            .mclk   (mclk),
            .resetn (resetn),
            .rise   (s_q.rise),
            .fall   (s_q.fall),
            .allow  (s_q.allow),
            .en_n   (out_enable_n[g]),                                  // [R1]
            .clk_p  (diff_clk_out_p[g]),
            .clk_n  (diff_clk_out_n[g])
        );
    end

    assign bus_address_latch_ref_copy_o  = s_q.ref_o;
    assign bus_address_latch_ref_copy_oe = s_q.ref_oe;
    assign pll_enable                    = s_q.pll_en;
    assign spread_code                   = s_q.spread;
    assign common_clock_mode             = s_q.mode_common;
    assign bus_addr_sel                  = s_q.addr_sel;
    assign startup_fault                 = s_q.fault;

    a_first_latch: assert property (@(posedge mclk) disable iff (!resetn) // [R2]
        s_q.st == ckg_pkg::CKG_ST_WAIT_PG && power_good_powerdown_n
        |=> s_q.latched && s_q.st == ckg_pkg::CKG_ST_START ##1 cfg.spread_field
        == (s_q.tri_sel == ckg_pkg::CKG_TRI_LOW ? 2'h0
            : s_q.tri_sel == ckg_pkg::CKG_TRI_MID ? 2'h2 : 2'h3))
        else $error("straps not taken on first power-good");
    a_straps_held: assert property (@(posedge mclk) disable iff (!resetn) // [R18]
        s_q.latched |=> $stable(s_q.tri_sel) && $stable(s_q.addr_sel))
        else $error("latched strap changed");
    a_pd_entry: assert property (@(posedge mclk) disable iff (!resetn) // [R3]
        s_q.st == ckg_pkg::CKG_ST_RUN && !power_good_powerdown_n
        |=> s_q.st == ckg_pkg::CKG_ST_PD && !s_q.pll_en ##1 !s_q.allow)
        else $error("power-down not entered");
    a_pd_exit: assert property (@(posedge mclk) disable iff (!resetn) // [R3]
        s_q.st == ckg_pkg::CKG_ST_PD && power_good_powerdown_n
        |=> s_q.st == ckg_pkg::CKG_ST_START && s_q.from_pd && s_q.timer == 17'h0)
        else $error("power-down exit wrong");
    a_lock_gate: assert property (@(posedge mclk) disable iff (!resetn) // [R12]
        s_q.allow |-> $past(pll_lock) && s_q.st == ckg_pkg::CKG_ST_RUN)
        else $error("outputs allowed without lock");
    a_wol_stop: assert property (@(posedge mclk) disable iff (!resetn) // [R16]
        s_q.st == ckg_pkg::CKG_ST_PD && !cfg.wol ##1 s_q.st == ckg_pkg::CKG_ST_PD
        |-> !s_q.ref_o)
        else $error("reference ran in power-down without wake-on-lan");
    a_spread_edge: assert property (@(posedge mclk) disable iff (!resetn) // [R13]
        $changed(s_q.spread) |-> $past(s_q.rise))
        else $error("spread changed away from a boundary");
    a_fault_bound: assert property (@(posedge mclk) disable iff (!resetn) // [R10]
        s_q.st == ckg_pkg::CKG_ST_START && s_q.from_pd && power_good_powerdown_n
        && !pll_lock && 32'(s_q.timer) >= DRVPD_CYC |=> s_q.fault)
        else $error("missed power-down exit deadline not flagged");
endmodule : ckg_ctrl
`default_nettype wire

//--- tb/ckg_board_model.sv
// Purpose: board side of the clock generator, pll lock and crystal
// Assumes: lock follows pll_enable lock_delay+1 cycles after it rises
// Notes:   lock drops at once when the pll is disabled, like a real loop
`default_nettype none
module ckg_board_model (
    input  wire logic        mclk,
    input  wire logic        resetn,
    input  wire logic        pll_enable,
    input  wire logic [15:0] lock_delay,
    output logic             pll_lock,
    output logic             xtal_in
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [15:0] cnt_q;
    logic        div_q;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cnt_q    <= 16'h0000;
            div_q    <= 1'b0;
            pll_lock <= 1'b0;
            xtal_in  <= 1'b0;
        end else begin
            div_q <= ~div_q;
            // slower than mclk, as the reference is
            if (div_q) begin
                xtal_in <= ~xtal_in;
            end
            if (!pll_enable) begin
                cnt_q    <= 16'h0000;
                pll_lock <= 1'b0;
            end else if (cnt_q < lock_delay) begin
                cnt_q <= cnt_q + 16'h0001;
            end else begin
                pll_lock <= 1'b1;
            end
        end
    end
endmodule : ckg_board_model
`default_nettype wire

//--- tb/tb_top.sv
// Purpose: self-checking bench of the clock generator control block
// Assumes: short start-up limits so the run stays brief
// Notes:   host never writes spread 00, nor touches the field after a low strap
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {logic wr; logic [2:0] a; logic [7:0] d;} ckg_row_s;

    logic       mclk = 1'b0;
    logic       resetn = 1'b0;
    logic       pg = 1'b0;
    logic [1:0] tri_sel = 2'h2;
    logic [5:0] oe_n = 6'h00;
    logic       strap_drv = 1'b1;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic [15:0] lock_delay = 16'h000a;
    logic [7:0] reg_rdata, rd_v;
    logic [5:0] p, n;
    logic [6:0] act;
    logic [1:0] spread_code;
    logic       pll_lock, xtal_in, pll_enable, ref_o, ref_oe, ref_pin;
    logic       comm_mode, addr_sel, fault;
    int         error_cnt = 0;
    int         n_tests = 0;
    int         i;
    // host rows: spread 00 never written, no field write after low strap
    ckg_row_s   rows[11] = '{'{1'b0, 3'h1, 8'h18}, '{1'b1, 3'h1, 8'h08}, '{1'b0, 3'h1, 8'h08},
        '{1'b1, 3'h1, 8'h10}, '{1'b0, 3'h1, 8'h10}, '{1'b1, 3'h3, 8'h20}, '{1'b0, 3'h3, 8'h20},
        '{1'b1, 3'h2, 8'hff}, '{1'b0, 3'h2, 8'h00}, '{1'b0, 3'h5, 8'h00}, '{1'b0, 3'h4, 8'h65}};

    always #12.5 mclk = ~mclk;
    // pull-down pin: strap drive until the device takes it over
    assign ref_pin = ref_oe ? ref_o : strap_drv;

    ckg_board_model board (.mclk(mclk), .resetn(resetn), .pll_enable(pll_enable),
        .lock_delay(lock_delay), .pll_lock(pll_lock), .xtal_in(xtal_in));

    ckg_ctrl #(.STAB_CYC(40), .DRVPD_CYC(20)) dut (
        .mclk(mclk), .resetn(resetn), .power_good_powerdown_n(pg),
        .spread_select_tri(tri_sel), .out_enable_n(oe_n), .xtal_in(xtal_in),
        .pll_lock(pll_lock), .bus_address_latch_ref_copy_i(ref_pin),
        .bus_address_latch_ref_copy_o(ref_o), .bus_address_latch_ref_copy_oe(ref_oe),
        .diff_clk_out_p(p), .diff_clk_out_n(n), .pll_enable(pll_enable),
        .spread_code(spread_code), .common_clock_mode(comm_mode), .bus_addr_sel(addr_sel),
        .startup_fault(fault), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : give_verdict

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk8

    task automatic chk1(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected flag at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk1

    // a bound that ran out ends the run
    task automatic waited(input logic ok);
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("unexpected wait bound at %0t: got %h exp %h", $time, ok, 1'b1);
            give_verdict();
        end
    endtask : waited

    task automatic step(input int k);
        repeat (k) begin
            @(posedge mclk);
            #1;
        end
    endtask : step

    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr_reg

    task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd_reg

    // which of ref copy and the six outputs moved in k cycles
    task automatic toggles(input int k, output logic [6:0] moved);
        logic [6:0] prev;
        moved = 7'h00;
        prev  = {ref_o, p};
        repeat (k) begin
            step(1);
            moved = moved | (prev ^ {ref_o, p});
            prev  = {ref_o, p};
        end
    endtask : toggles

    initial begin
        repeat (60000) @(posedge mclk);
        error_cnt++;
        give_verdict();
    end

    initial begin
        repeat (5) @(posedge mclk);
        resetn <= 1'b1;
        step(2);
        chk8({2'h0, p | n}, 8'h00);
        rd_reg(3'h4, rd_v);
        chk8(rd_v, 8'h00);
        @(posedge mclk);
        pg <= 1'b1;
        step(3);
        chk1(addr_sel, 1'b1);
        chk1(ref_oe, 1'b1);
        chk1(comm_mode, 1'b1);
        for (i = 0; i < 40 && !pll_lock; i++) begin
            chk8({2'h0, p | n}, 8'h00);
            step(1);
        end
        for (i = 0; i < 16 && p !== 6'h3f; i++) step(1);
        waited(p === 6'h3f);
        chk8({2'h0, n}, 8'h00);
        chk1(pll_enable, 1'b1);
        step(2);
        chk8({2'h0, n}, 8'h3f);
        chk8({6'h00, spread_code}, 8'h03);
        foreach (rows[r]) begin
            if (rows[r].wr) begin
                wr_reg(rows[r].a, rows[r].d);
                step(6);
                if (rows[r].a == 3'h1) chk8({6'h00, spread_code}, {6'h00, rows[r].d[4:3]});
            end else begin
                rd_reg(rows[r].a, rd_v);
                chk8(rd_v, rows[r].d);
            end
        end
        @(posedge mclk);
        oe_n <= 6'h08;
        step(12);
        toggles(16, act);
        chk8({2'h0, act[5:0]}, 8'h37);
        chk8({2'h0, p[3], n[3], 4'h0}, 8'h00);
        @(posedge mclk);
        oe_n <= 6'h00;
        for (i = 0; i < 12 && !p[3]; i++) step(1);
        waited(p[3]);
        @(posedge mclk);
        tri_sel   <= 2'h0;
        strap_drv <= 1'b0;
        pg        <= 1'b0;
        step(16);
        toggles(12, act);
        chk8({1'b0, act}, 8'h40);
        chk8({2'h0, p | n}, 8'h00);
        chk1(pll_enable, 1'b0);
        rd_reg(3'h4, rd_v);
        chk8(rd_v & 8'h03, 8'h03);
        wr_reg(3'h3, 8'h00);
        step(4);
        toggles(12, act);
        chk8({1'b0, act}, 8'h00);
        chk1(ref_o, 1'b0);
        @(posedge mclk);
        pg <= 1'b1;
        for (i = 0; i < 60 && p !== 6'h3f; i++) step(1);
        waited(p === 6'h3f);
        chk1(addr_sel, 1'b1);
        chk1(comm_mode, 1'b1);
        chk8({6'h00, spread_code}, 8'h02);
        @(posedge mclk);
        resetn     <= 1'b0;
        lock_delay <= 16'h0064;
        pg         <= 1'b0;
        step(3);
        chk8({2'h0, p | n}, 8'h00);
        @(posedge mclk);
        resetn <= 1'b1;
        step(2);
        @(posedge mclk);
        pg <= 1'b1;
        step(60);
        chk1(fault, 1'b1);
        chk8({2'h0, p | n}, 8'h00);
        chk1(comm_mode, 1'b0);
        chk1(addr_sel, 1'b0);
        for (i = 0; i < 80 && p !== 6'h3f; i++) step(1);
        waited(p === 6'h3f);
        chk8({6'h00, spread_code}, 8'h00);
        chk1(fault, 1'b1);
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire
